// ---- eac_pkg.sv ----
// eac_pkg: constants and types for the energy accumulator input config
// assumes one metering clock, apb byte addressing, 32-bit data
package eac_pkg;

  localparam int NACC = 3;
  localparam int DW   = 24;
  localparam int RW   = 26;

  localparam logic [31:0] OFS_CTRL   = 32'h0000_0004;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0008;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'hffff_ff00;

  // field base per accumulator: index 0 is acc2, 1 acc3, 2 acc4
  localparam int ACC_BASE [NACC] = '{8, 16, 24};
  localparam int PROC_LSB  = 0;
  localparam int TYPE_LSB  = 2;
  localparam int BEN_POS   = 4;
  localparam int AEN_POS   = 5;
  localparam int MODE_LSB  = 6;

  localparam int STS_ACTIVE_LSB = 0;
  localparam int STS_NEG_LSB    = 4;

  typedef enum logic [1:0] {
    MODE_POWER,
    MODE_RMS,
    MODE_CONST,
    MODE_FUND
  } eac_mode_t;

  typedef enum logic [1:0] {
    PROC_POS,
    PROC_NEG,
    PROC_ORIG,
    PROC_ABS
  } eac_proc_t;

  typedef struct packed {
    eac_mode_t  mode;
    logic       aEn;
    logic       bEn;
    logic [1:0] ctype;
    eac_proc_t  proc;
  } eac_acc_cfg_t;

  typedef struct packed {
    logic signed [DW-1:0] actA;
    logic signed [DW-1:0] reaA;
    logic signed [DW-1:0] appA;
    logic signed [DW-1:0] rmsA;
    logic signed [DW-1:0] actB;
    logic signed [DW-1:0] reaB;
    logic signed [DW-1:0] appB;
    logic signed [DW-1:0] rmsB;
    logic signed [DW-1:0] constVal;
    logic signed [DW-1:0] fundVal;
  } eac_samples_t;

endpackage : eac_pkg

// ---- eac_value_cond.sv ----
// eac_value_cond: conditions one accumulator input value
// assumes the raw value never reaches the most negative code
`timescale 1ns/100ps
`default_nettype none

module eac_value_cond
  import eac_pkg::*;
(
  input  wire logic signed [RW-1:0] rawVal,
  input  wire eac_proc_t            proc,
  output logic signed [RW-1:0]      condVal
);

  always_comb begin
    case (proc)
      PROC_POS: begin
        condVal = rawVal[RW-1] ? '0 : rawVal;
      end
      // negative part is added as its magnitude
      PROC_NEG: begin
        condVal = rawVal[RW-1] ? -rawVal : '0;
      end
      PROC_ORIG: begin
        condVal = rawVal;
      end
      PROC_ABS: begin
        condVal = rawVal[RW-1] ? -rawVal : rawVal;
      end
      default: begin
        condVal = '0;
      end
    endcase
  end

endmodule : eac_value_cond

`default_nettype wire

// ---- eac_input_config.sv ----
// eac_input_config: apb register for accumulator 2..4 input selection
// assumes samples come from datapath logic on the same clock
`timescale 1ns/100ps
`default_nettype none

module eac_input_config
  import eac_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               sampleStb,
  input  wire eac_samples_t       samples,
  output eac_acc_cfg_t [NACC-1:0] accCfg,
  output logic [NACC-1:0][RW-1:0] accIn,
  output logic                    accInValid
);

  typedef struct packed {
    logic [31:0]             ctrl;
    logic [31:0]             rdata;
    logic [NACC-1:0][RW-1:0] accVal;
    logic                    accVld;
    logic [NACC-1:0]         active;
    logic [NACC-1:0]         neg;
  } eac_state_t;

  eac_state_t st_ff;
  eac_state_t nxt_st;

  eac_acc_cfg_t [NACC-1:0] cfgW;
  logic [NACC-1:0][RW-1:0] rawW;
  logic [NACC-1:0][RW-1:0] condW;
  logic [NACC-1:0]         usedW;

  logic        setupPh;
  logic        accessPh;
  logic        hitCtrl;
  logic        hitStatus;
  logic        mapped;
  logic [31:0] statusWord;
  logic [31:0] readWord;

  function automatic logic signed [RW-1:0] sx(
    input logic signed [DW-1:0] v
  );
    sx = {{(RW-DW){v[DW-1]}}, v};
  endfunction : sx

  assign setupPh   = psel & ~penable;
  assign accessPh  = psel & penable;
  assign hitCtrl   = (paddr == OFS_CTRL);
  assign hitStatus = (paddr == OFS_STATUS);
  assign mapped    = hitCtrl | hitStatus;

  // zero wait states: read data is caught in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~mapped;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[STS_ACTIVE_LSB +: NACC] = st_ff.active;
    statusWord[STS_NEG_LSB +: NACC]    = st_ff.neg;
  end

  always_comb begin
    if (hitCtrl) begin
      readWord = st_ff.ctrl;
    end else if (hitStatus) begin
      readWord = statusWord;
    end else begin
      readWord = 32'h0000_0000;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NACC; gi++) begin : g_acc
      logic signed [RW-1:0] aSel;
      logic signed [RW-1:0] bSel;
      logic signed [DW-1:0] pA;
      logic signed [DW-1:0] pB;

      assign cfgW[gi].mode =
        eac_mode_t'(st_ff.ctrl[ACC_BASE[gi]+MODE_LSB +: 2]);
      assign cfgW[gi].aEn = st_ff.ctrl[ACC_BASE[gi]+AEN_POS];
      assign cfgW[gi].bEn = st_ff.ctrl[ACC_BASE[gi]+BEN_POS];
      assign cfgW[gi].ctype =
        st_ff.ctrl[ACC_BASE[gi]+TYPE_LSB +: 2];
      assign cfgW[gi].proc =
        eac_proc_t'(st_ff.ctrl[ACC_BASE[gi]+PROC_LSB +: 2]);

      always_comb begin
        case (cfgW[gi].ctype)
          2'h1: begin
            pA = samples.reaA;
            pB = samples.reaB;
          end
          2'h2: begin
            pA = samples.appA;
            pB = samples.appB;
          end
          default: begin
            pA = samples.actA;
            pB = samples.actB;
          end
        endcase
      end

      always_comb begin
        aSel = '0;
        bSel = '0;
        rawW[gi] = '0;
        usedW[gi] = 1'b0;
        case (cfgW[gi].mode)
          MODE_POWER: begin
            aSel = cfgW[gi].aEn ? sx(pA) : '0;
            bSel = cfgW[gi].bEn ? sx(pB) : '0;
            rawW[gi] = RW'(aSel + bSel);
            usedW[gi] = cfgW[gi].aEn | cfgW[gi].bEn;
          end
          MODE_RMS: begin
            aSel = cfgW[gi].aEn ? sx(samples.rmsA) : '0;
            bSel = cfgW[gi].bEn ? sx(samples.rmsB) : '0;
            if (cfgW[gi].ctype[1]) begin
              rawW[gi] = RW'(aSel - bSel);
            end else begin
              rawW[gi] = RW'(aSel + bSel);
            end
            usedW[gi] = cfgW[gi].aEn | cfgW[gi].bEn;
          end
          MODE_CONST: begin
            rawW[gi] = sx(samples.constVal);
            usedW[gi] = 1'b1;
          end
          MODE_FUND: begin
            rawW[gi] = sx(samples.fundVal);
            usedW[gi] = 1'b1;
          end
          default: begin
            rawW[gi] = '0;
          end
        endcase
      end

      eac_value_cond u_cond (
        .rawVal  (rawW[gi]),
        .proc    (cfgW[gi].proc),
        .condVal (condW[gi])
      );
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.accVld = sampleStb;
    if (setupPh) begin
      nxt_st.rdata = readWord;
    end
    // a write lands only on the access edge; status is read only
    if (accessPh && pwrite && hitCtrl) begin
      nxt_st.ctrl = pwdata & CTRL_WMASK;
    end
    if (sampleStb) begin
      for (int k = 0; k < NACC; k++) begin
        nxt_st.accVal[k] = usedW[k] ? condW[k] : '0;
        nxt_st.active[k] = usedW[k] && (condW[k] != '0);
        nxt_st.neg[k]    = usedW[k] && rawW[k][RW-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nxt_st_reset: begin
        st_ff.ctrl   <= CTRL_RESET;
        st_ff.rdata  <= 32'h0000_0000;
        st_ff.accVal <= '0;
        st_ff.accVld <= 1'b0;
        st_ff.active <= '0;
        st_ff.neg    <= '0;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata     = st_ff.rdata;
  assign accCfg     = cfgW;
  assign accIn      = st_ff.accVal;
  assign accInValid = st_ff.accVld;

endmodule : eac_input_config

`default_nettype wire

// ---- eac_checker.sv ----
// eac_checker: assertions on the input config register ports
// assumes zero-wait apb and one-cycle sample latency
`timescale 1ns/100ps
`default_nettype none

module eac_checker
  import eac_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    sampleStb,
  input wire eac_samples_t            samples,
  input wire eac_acc_cfg_t [NACC-1:0] accCfg,
  input wire logic [NACC-1:0][RW-1:0] accIn,
  input wire logic                    accInValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sWr;
    psel && !penable ##1 psel && penable && pwrite && paddr == 32'h4;
  endsequence

  AST_CFG_WR: assert property (
    sWr |=> accCfg == $past(pwdata[31:8]))
    else $error("config differs from written word");
  AST_CFG_HOLD: assert property (
    !(psel && penable && pwrite) |=> $stable(accCfg))
    else $error("config moved without a write");
  AST_RD: assert property (
    psel && penable && !pwrite && paddr == 32'h4
    |-> prdata == {accCfg, 8'h00})
    else $error("read data differs from config");
  AST_ERR: assert property (psel && penable && paddr != 32'h4
    && paddr != 32'h8 |-> pslverr && pready)
    else $error("unmapped access not refused");
  AST_VALID: assert property (sampleStb |=> accInValid)
    else $error("no valid after strobe");
  AST_OFF: assert property (
    sampleStb && accCfg[0].mode inside {MODE_POWER, MODE_RMS}
    && !accCfg[0].aEn && !accCfg[0].bEn |=> accIn[0] == '0)
    else $error("disabled channels still add");
  AST_CONST: assert property (
    sampleStb && accCfg[1].mode == MODE_CONST
    && accCfg[1].proc == PROC_ORIG
    |=> accIn[1] == RW'($past(samples.constVal)))
    else $error("constant not passed");
  AST_FUND: assert property (
    sampleStb && accCfg[2].mode == MODE_FUND
    && accCfg[2].proc == PROC_ORIG
    |=> accIn[2] == RW'($past(samples.fundVal)))
    else $error("fundamental not passed");
endmodule : eac_checker

bind eac_input_config eac_checker eac_checker_i (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sampleStb(sampleStb), .samples(samples), .accCfg(accCfg),
  .accIn(accIn), .accInValid(accInValid));

`default_nettype wire

// ---- testbench.sv ----
// testbench: apb and sample-path checks of eac_input_config
// assumes eac_checker is bound to the design
`timescale 1ns/100ps
`default_nettype none

module testbench
  import eac_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic sampleStb, accInValid;
  logic [31:0] paddr, pwdata, prdata, rd, w;
  eac_samples_t samples;
  eac_acc_cfg_t [NACC-1:0] accCfg;
  logic [NACC-1:0][RW-1:0] accIn;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h0001_1f43;

  eac_input_config eac_input_config_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleStb(sampleStb), .samples(samples), .accCfg(accCfg),
    .accIn(accIn), .accInValid(accInValid));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [RW-1:0] expAcc(eac_acc_cfg_t c, eac_samples_t s);
    logic signed [RW-1:0] a, b, x;
    a = c.ctype == 2'h1 ? s.reaA : c.ctype == 2'h2 ? s.appA : s.actA;
    b = c.ctype == 2'h1 ? s.reaB : c.ctype == 2'h2 ? s.appB : s.actB;
    if (c.mode == MODE_RMS) begin
      a = s.rmsA;
      b = s.rmsB;
    end
    if (!c.aEn) a = '0;
    if (!c.bEn) b = '0;
    x = (c.mode == MODE_RMS && c.ctype[1]) ? a - b : a + b;
    if (c.mode == MODE_CONST) x = s.constVal;
    if (c.mode == MODE_FUND) x = s.fundVal;
    case (c.proc)
      PROC_POS: x = x < 0 ? '0 : x;
      PROC_NEG: x = x < 0 ? -x : '0;
      PROC_ABS: x = x < 0 ? -x : x;
      default: ;
    endcase
    return x;
  endfunction : expAcc

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(logic wr, logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // expectation follows the written word, not the design's decoded config
  task automatic strobe();
    logic [10*DW-1:0]        nv;
    eac_acc_cfg_t [NACC-1:0] cfgExp;
    eac_acc_cfg_t            c;
    logic [RW-1:0]           v;
    logic [31:0]             sts;
    cfgExp = w[31:8];
    sts = 32'h0000_0000;
    for (int k = 0; k < 10; k++) nv[k*DW +: DW] = DW'(rnd());
    @(posedge clk);
    samples <= nv;
    sampleStb <= 1'b1;
    @(posedge clk);
    sampleStb <= 1'b0;
    #1;
    chk(accInValid, 1'b1);
    for (int k = 0; k < NACC; k++) begin
      c = cfgExp[k];
      v = expAcc(c, nv);
      chk(accIn[k], v);
      sts[STS_ACTIVE_LSB + k] = (v != '0);
      c.proc = PROC_ORIG;
      v = expAcc(c, nv);
      sts[STS_NEG_LSB + k] = v[RW-1];
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, sts);
  endtask : strobe

  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard: a full run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    {rst, psel, penable, pwrite, sampleStb} = 5'h10;
    paddr = '0;
    pwdata = '0;
    samples = '0;
    w = CTRL_RESET;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    strobe();
    // first words are corner cases: every mode, both channels off in rms, rms diff
    for (int i = 0; i < 40; i++) begin
      w = rnd();
      if (i < 4) w = {{3{2'(i), 2'h3, 2'(i), 2'(i)}}, 8'h5a};
      if (i == 4) w = 32'hdaa2_4b5a;
      if (i == 5) w = 32'h7b7b_7b00;
      apb(1'b1, OFS_CTRL, w);
      #1;
      chk(accCfg, w[31:8]);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, w & CTRL_WMASK);
      strobe();
    end
    // second reset in mid-run brings every field back to zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    w = CTRL_RESET;
    #1;
    chk(accCfg, w[31:8]);
    strobe();
    apb(1'b1, 32'h10, 32'hffff_ffff);
    chk(err, 1'b1);
    apb(1'b1, OFS_STATUS, 32'hffff_ffff);
    chk(err, 1'b0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, w & CTRL_WMASK);
    final_report();
  end
endmodule : testbench

`default_nettype wire
